// [core/pwr_seq_pkg.sv]
// Shared timing constants and states for the module power and reset sequencer
package pwr_seq_pkg;

  // ----------------------------------------------------------------
  // Clock rate
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // ----------------------------------------------------------------
  // Times in their own units
  // ----------------------------------------------------------------
  localparam int unsigned ON_PULSE_MS      = 500;   // Host power-on pulse
  localparam int unsigned ON_DETECT_MS     = 100;   // Least pulse the module accepts
  localparam int unsigned OFF_PULSE_MS     = 1000;  // Shutdown pulse, 1 s
  localparam int unsigned STATUS_MIN_MS    = 22;    // Earliest status report
  localparam int unsigned USB_READY_S      = 10;
  localparam int unsigned UART_READY_S     = 6;
  localparam int unsigned RESET_MIN_MS     = 100;
  localparam int unsigned RESET_MAX_MS     = 450;
  localparam int unsigned RESET_PULSE_MS   = 200;   // Host reset pulse, inside window
  localparam int unsigned BOOT_MS          = 50;    // Module model boot time

  // ----------------------------------------------------------------
  // Derived cycle counts (all exceed 4096: defaults for top parameters)
  // ----------------------------------------------------------------
  localparam int unsigned ON_PULSE_CYC    = ON_PULSE_MS * CYC_PER_MS;
  localparam int unsigned ON_DETECT_CYC   = ON_DETECT_MS * CYC_PER_MS;
  localparam int unsigned OFF_PULSE_CYC   = OFF_PULSE_MS * CYC_PER_MS;
  localparam int unsigned STATUS_MIN_CYC  = STATUS_MIN_MS * CYC_PER_MS;
  localparam int unsigned USB_READY_CYC   = USB_READY_S * 1000 * CYC_PER_MS;
  localparam int unsigned UART_READY_CYC  = UART_READY_S * 1000 * CYC_PER_MS;
  localparam int unsigned RESET_MIN_CYC   = RESET_MIN_MS * CYC_PER_MS;
  localparam int unsigned RESET_PULSE_CYC = RESET_PULSE_MS * CYC_PER_MS;
  localparam int unsigned BOOT_CYC        = BOOT_MS * CYC_PER_MS;

  localparam int unsigned CNT_W = 28;
  localparam logic [27:0] CNT_ZERO = 28'h0000000;
  localparam logic [27:0] CNT_ONE  = 28'h0000001;

  // Synchroniser reset values (pins idle high, or low for the rail)
  localparam logic [2:0] SYNC_IDLE_HI = 3'h7;
  localparam logic [2:0] SYNC_IDLE_LO = 3'h0;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MOD_OFF     = 5'h01,
    MOD_BOOT    = 5'h02,
    MOD_ON      = 5'h04,
    MOD_SHUT    = 5'h08,
    MOD_RESET   = 5'h10
  } mod_state_e;

  typedef enum logic [5:0] {
    HST_IDLE    = 6'h01,
    HST_KEY_ON  = 6'h02,
    HST_WAIT_UP = 6'h04,
    HST_RUN     = 6'h08,
    HST_KEY_OFF = 6'h10,
    HST_RESET   = 6'h20
  } host_state_e;

endpackage

// [core/pwr_seq_if.sv]
// Pin-level link between the host sequencer and the modem module end
`timescale 1ns/1ps
`default_nettype none
interface pwr_seq_if;
  logic power_key_n;      // Host drives, active low
  logic reset_n;          // Host drives, active low
  logic aux_rail_out;     // Module 1.8 V rail, high when powered
  logic status_o;         // Module status output level
  logic status_oe_n;      // Low while module pulls status
  logic status_pin;       // Resolved level with external pull-up

  // Open-drain resolution with pull-up
  assign status_pin = status_oe_n ? 1'b1 : status_o;

  modport module_end (input power_key_n, input reset_n,
                      output aux_rail_out, output status_o, output status_oe_n);
  modport host_end   (output power_key_n, output reset_n,
                      input aux_rail_out, input status_pin);
endinterface
`default_nettype wire

// [core/modem_pwr_end.sv]
// Module end: recognises power key and reset pulses and reports power state
`timescale 1ns/1ps
`default_nettype none
module modem_pwr_end #(
  parameter int unsigned ON_DET_CYC  = pwr_seq_pkg::ON_DETECT_CYC,
  parameter int unsigned OFF_DET_CYC = pwr_seq_pkg::OFF_PULSE_CYC,
  parameter int unsigned STAT_CYC    = pwr_seq_pkg::STATUS_MIN_CYC,
  parameter int unsigned RST_DET_CYC = pwr_seq_pkg::RESET_MIN_CYC,
  parameter int unsigned BOOT_CYCS   = pwr_seq_pkg::BOOT_CYC
) (
  input  wire logic core_clk,   // 25 MHz clock
  input  wire logic arst_n,     // Async reset, active low
  pwr_seq_if.module_end pins,   // Link pins
  output logic      powered,    // Module is up
  output logic      rebooting   // Reset pulse seen, rebooting
);

  // ----------------------------------------------------------------
  // Pin synchronisers, three stages
  // ----------------------------------------------------------------
  logic [2:0] key_sync_q;
  logic [2:0] rst_sync_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      key_sync_q <= pwr_seq_pkg::SYNC_IDLE_HI;
      rst_sync_q <= pwr_seq_pkg::SYNC_IDLE_HI;
    end else begin
      key_sync_q <= {key_sync_q[1:0], pins.power_key_n};
      rst_sync_q <= {rst_sync_q[1:0], pins.reset_n};
    end
  end
  // Level only changes once stages two and three agree
  logic key_lvl_q, key_lvl_d, rst_lvl_q, rst_lvl_d;
  always_comb begin
    key_lvl_d = (key_sync_q[2] == key_sync_q[1]) ? key_sync_q[2] : key_lvl_q;
    rst_lvl_d = (rst_sync_q[2] == rst_sync_q[1]) ? rst_sync_q[2] : rst_lvl_q;
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  pwr_seq_pkg::mod_state_e st_q, st_d;
  logic [27:0] key_cnt_q, key_cnt_d;   // Length of current key low
  logic [27:0] rst_cnt_q, rst_cnt_d;   // Length of current reset low
  logic [27:0] t_cnt_q, t_cnt_d;       // Time since power-on request

  always_comb begin
    st_d      = st_q;
    key_cnt_d = key_lvl_q ? pwr_seq_pkg::CNT_ZERO : key_cnt_q + pwr_seq_pkg::CNT_ONE;
    rst_cnt_d = rst_lvl_q ? pwr_seq_pkg::CNT_ZERO : rst_cnt_q + pwr_seq_pkg::CNT_ONE;
    t_cnt_d   = t_cnt_q + pwr_seq_pkg::CNT_ONE;
    unique case (st_q)
      pwr_seq_pkg::MOD_OFF: begin
        t_cnt_d = key_lvl_q ? pwr_seq_pkg::CNT_ZERO : t_cnt_d;
        // 100 ms key low powers on
        if (!key_lvl_q && key_cnt_q >= 28'(ON_DET_CYC - 1)) begin
          st_d = pwr_seq_pkg::MOD_BOOT;
        end
      end
      pwr_seq_pkg::MOD_BOOT: begin
        // status no sooner than 22 ms
        if (t_cnt_q >= 28'(STAT_CYC) && t_cnt_q >= 28'(BOOT_CYCS)) begin
          st_d = pwr_seq_pkg::MOD_ON;
        end
      end
      pwr_seq_pkg::MOD_ON: begin
        // 1 s press then release shuts down
        // Counter lags the low level by one, as for power-on
        if (key_lvl_d && !key_lvl_q && key_cnt_q >= 28'(OFF_DET_CYC - 1)) begin
          st_d = pwr_seq_pkg::MOD_SHUT;
        end else if (!rst_lvl_q && rst_cnt_q >= 28'(RST_DET_CYC - 1)) begin
          st_d = pwr_seq_pkg::MOD_RESET;
        end
      end
      pwr_seq_pkg::MOD_SHUT: begin
        // Orderly shutdown, wait for key released
        if (key_lvl_q) begin
          st_d = pwr_seq_pkg::MOD_OFF;
        end
      end
      pwr_seq_pkg::MOD_RESET: begin
        // Reboot once reset released, restart status timer
        t_cnt_d = pwr_seq_pkg::CNT_ZERO;
        if (rst_lvl_q) begin
          st_d = pwr_seq_pkg::MOD_BOOT;
        end
      end
      default: st_d = pwr_seq_pkg::MOD_OFF;
    endcase
    // Saturate so long presses do not wrap
    if (key_cnt_q == 28'hfffffff) key_cnt_d = key_cnt_q;
    if (rst_cnt_q == 28'hfffffff) rst_cnt_d = rst_cnt_q;
    if (t_cnt_q == 28'hfffffff) t_cnt_d = t_cnt_q;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= pwr_seq_pkg::MOD_OFF;
      key_lvl_q <= 1'b1;
      rst_lvl_q <= 1'b1;
      key_cnt_q <= pwr_seq_pkg::CNT_ZERO;
      rst_cnt_q <= pwr_seq_pkg::CNT_ZERO;
      t_cnt_q   <= pwr_seq_pkg::CNT_ZERO;
    end else begin
      st_q      <= st_d;
      key_lvl_q <= key_lvl_d;
      rst_lvl_q <= rst_lvl_d;
      key_cnt_q <= key_cnt_d;
      rst_cnt_q <= rst_cnt_d;
      t_cnt_q   <= t_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // rail up while running
  // status pulled low only when on
  assign pins.aux_rail_out = (st_q == pwr_seq_pkg::MOD_ON);
  assign pins.status_o     = 1'b0;
  assign pins.status_oe_n  = (st_q != pwr_seq_pkg::MOD_ON);
  assign powered           = (st_q == pwr_seq_pkg::MOD_ON);
  assign rebooting         = (st_q == pwr_seq_pkg::MOD_RESET);

endmodule
`default_nettype wire

// [core/host_pwr_seq.sv]
// Host sequencer: drives power key and reset pulses and tracks module readiness
//
// Overview of operation
// - Power-on holds key low at least 500 ms.
// - Module accepts key low of 100 ms.
// - One second press while running shuts down.
// - Rail high at 1.8 V means powered.
// - Status not valid before 22 ms.
// - Expect USB usable ten seconds later.
// - Expect main serial usable six seconds later.
// - Reset pulse lasts between 100 and 450 ms.
// - Status low only while module powered.
`timescale 1ns/1ps
`default_nettype none
module host_pwr_seq #(
  parameter int unsigned ON_CYC    = pwr_seq_pkg::ON_PULSE_CYC,
  parameter int unsigned OFF_CYC   = pwr_seq_pkg::OFF_PULSE_CYC,
  parameter int unsigned STAT_CYC  = pwr_seq_pkg::STATUS_MIN_CYC,
  parameter int unsigned RST_CYC   = pwr_seq_pkg::RESET_PULSE_CYC,
  parameter int unsigned USB_CYC   = pwr_seq_pkg::USB_READY_CYC,
  parameter int unsigned UART_CYC  = pwr_seq_pkg::UART_READY_CYC
) (
  input  wire logic core_clk,     // 25 MHz clock
  input  wire logic arst_n,       // Async reset, active low
  pwr_seq_if.host_end pins,       // Link pins
  input  wire logic req_on,       // Pulse: power the module on
  input  wire logic req_off,      // Pulse: shut the module down
  input  wire logic req_reset,    // Pulse: hard reset the module
  output logic      busy,         // Sequence in progress
  output logic      mod_up,       // Module reported powered
  output logic      uart_ready,   // Serial interface expected usable
  output logic      usb_ready     // USB interface expected usable
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] rail_sync_q;
  logic [2:0] stat_sync_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rail_sync_q <= pwr_seq_pkg::SYNC_IDLE_LO;
      stat_sync_q <= pwr_seq_pkg::SYNC_IDLE_HI;
    end else begin
      rail_sync_q <= {rail_sync_q[1:0], pins.aux_rail_out};
      stat_sync_q <= {stat_sync_q[1:0], pins.status_pin};
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  pwr_seq_pkg::host_state_e st_q, st_d;
  logic [27:0] cnt_q, cnt_d;     // Pulse timer
  logic [27:0] up_q, up_d;       // Time since power-on request
  logic        rail_q, rail_d;
  logic        stat_q, stat_d;   // Status low seen, filtered
  logic        key_n_q, key_n_d;
  logic        rst_n_q, rst_n_d;
  logic        up_q_flag, up_d_flag;
  logic        uart_q, uart_d, usb_q, usb_d;

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q + pwr_seq_pkg::CNT_ONE;
    up_d      = (up_q == 28'hfffffff) ? up_q : up_q + pwr_seq_pkg::CNT_ONE;
    rail_d    = (rail_sync_q[2] == rail_sync_q[1]) ? rail_sync_q[2] : rail_q;
    stat_d    = (stat_sync_q[2] == stat_sync_q[1]) ? !stat_sync_q[2] : stat_q;
    key_n_d   = 1'b1;
    rst_n_d   = 1'b1;
    up_d_flag = up_q_flag;
    uart_d    = uart_q;
    usb_d     = usb_q;
    unique case (st_q)
      pwr_seq_pkg::HST_IDLE: begin
        cnt_d = pwr_seq_pkg::CNT_ZERO;
        if (req_on) begin
          st_d = pwr_seq_pkg::HST_KEY_ON;
          up_d = pwr_seq_pkg::CNT_ZERO;
        end
      end
      pwr_seq_pkg::HST_KEY_ON: begin
        key_n_d = 1'b0;
        // Count starts at zero on entry, so this gives ON_CYC low cycles
        if (cnt_q >= 28'(ON_CYC)) begin
          key_n_d = 1'b1;
          st_d    = pwr_seq_pkg::HST_WAIT_UP;
        end
      end
      pwr_seq_pkg::HST_WAIT_UP: begin
        // rail and status after 22 ms
        if (rail_q && stat_q && up_q >= 28'(STAT_CYC)) begin
          up_d_flag = 1'b1;
          st_d      = pwr_seq_pkg::HST_RUN;
        end
      end
      pwr_seq_pkg::HST_RUN: begin
        cnt_d = pwr_seq_pkg::CNT_ZERO;
        // only one pulse at a time
        if (req_reset) begin
          st_d = pwr_seq_pkg::HST_RESET;
        end else if (req_off) begin
          st_d = pwr_seq_pkg::HST_KEY_OFF;
        end
      end
      pwr_seq_pkg::HST_KEY_OFF: begin
        // key low 1 s then release
        key_n_d = 1'b0;
        if (cnt_q >= 28'(OFF_CYC)) begin
          key_n_d   = 1'b1;
          up_d_flag = 1'b0;
          uart_d    = 1'b0;
          usb_d     = 1'b0;
          st_d      = pwr_seq_pkg::HST_IDLE;
        end
      end
      pwr_seq_pkg::HST_RESET: begin
        // reset low 200 ms, inside window
        rst_n_d = 1'b0;
        if (cnt_q >= 28'(RST_CYC)) begin
          rst_n_d   = 1'b1;
          up_d      = pwr_seq_pkg::CNT_ZERO;
          up_d_flag = 1'b0;
          uart_d    = 1'b0;
          usb_d     = 1'b0;
          st_d      = pwr_seq_pkg::HST_WAIT_UP;
        end
      end
      default: st_d = pwr_seq_pkg::HST_IDLE;
    endcase
    // serial after 6 s
    // Next flag gates, so a reset or shutdown clear is not overridden
    if (up_d_flag && up_q >= 28'(UART_CYC)) uart_d = 1'b1;
    if (up_d_flag && up_q >= 28'(USB_CYC)) usb_d = 1'b1;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= pwr_seq_pkg::HST_IDLE;
      cnt_q     <= pwr_seq_pkg::CNT_ZERO;
      up_q      <= pwr_seq_pkg::CNT_ZERO;
      rail_q    <= 1'b0;
      stat_q    <= 1'b0;
      key_n_q   <= 1'b1;
      rst_n_q   <= 1'b1;
      up_q_flag <= 1'b0;
      uart_q    <= 1'b0;
      usb_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      up_q      <= up_d;
      rail_q    <= rail_d;
      stat_q    <= stat_d;
      key_n_q   <= key_n_d;
      rst_n_q   <= rst_n_d;
      up_q_flag <= up_d_flag;
      uart_q    <= uart_d;
      usb_q     <= usb_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, pins from flops
  // ----------------------------------------------------------------
  assign pins.power_key_n = key_n_q;
  assign pins.reset_n     = rst_n_q;
  assign busy       = (st_q != pwr_seq_pkg::HST_IDLE) && (st_q != pwr_seq_pkg::HST_RUN);
  assign mod_up     = up_q_flag;
  assign uart_ready = uart_q;
  assign usb_ready  = usb_q;

endmodule
`default_nettype wire

// [verification/pwr_seq_properties.sv]
// Pin-level properties of the host to module power and reset link
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_properties #(
  parameter int ON_CYC   = 50,
  parameter int OFF_CYC  = 100,
  parameter int RST_CYC  = 20,
  parameter int STAT_CYC = 5
) (
  input wire logic core_clk,      // Link clock
  input wire logic arst_n,        // Async reset, active low
  input wire logic power_key_n,   // Key, active low
  input wire logic reset_n,       // Module reset, active low
  input wire logic aux_rail_out,  // Rail, high when powered
  input wire logic status_o,      // Status drive level
  input wire logic status_oe_n,   // Low while status pulled
  input wire logic status_pin     // Resolved status level
);
  // ----------------------------------------------------------------
  // Low-time counters
  // ----------------------------------------------------------------
  int key_lo_q, key_lo_d, rst_lo_q, rst_lo_d;

  // Cleared on release, so each pulse is measured alone
  always_comb begin
    key_lo_d = power_key_n ? 0 : key_lo_q + 1;
    rst_lo_d = reset_n ? 0 : rst_lo_q + 1;
  end

  // Registers only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      key_lo_q <= 0;
      rst_lo_q <= 0;
    end else begin
      key_lo_q <= key_lo_d;
      rst_lo_q <= rst_lo_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_key_reset_apart: assert property (power_key_n || reset_n)
    else $error("key and reset low together");
  a_on_press_width: assert property ($rose(power_key_n) |-> key_lo_q >= ON_CYC)
    else $error("key press too short");
  a_key_hold_bound: assert property (key_lo_q <= OFF_CYC + 1)
    else $error("key held too long");
  a_press_boots_rail: assert property (key_lo_q == 45 |-> aux_rail_out)
    else $error("press did not power module");
  a_status_not_early: assert property (($fell(status_pin) && !power_key_n) |-> key_lo_q >= STAT_CYC)
    else $error("status reported too early");
  a_status_pull_on: assert property (!status_oe_n |-> (aux_rail_out && status_o == 1'b0 && !status_pin))
    else $error("status pulled while off");
  a_status_float_off: assert property (!aux_rail_out |-> (status_oe_n && status_pin))
    else $error("status not released while off");
  a_reset_width: assert property ($rose(reset_n) |-> rst_lo_q inside {[RST_CYC:RST_CYC + 1]})
    else $error("reset pulse width wrong");
  a_off_drops_rail: assert property (($rose(power_key_n) && key_lo_q >= OFF_CYC && aux_rail_out)
                                     |-> ##[1:12] !aux_rail_out)
    else $error("long press left rail up");

  // Main scenarios reached
  c_rail_up: cover property ($rose(aux_rail_out));
  c_reset_done: cover property ($rose(reset_n));
  c_long_press: cover property ($rose(power_key_n) && key_lo_q >= OFF_CYC);
endmodule
`default_nettype wire

// [verification/module_power_reset_sequencer_bench.sv]
// Self-checking bench: host sequencer facing the module end
`timescale 1ns/1ps
`default_nettype none
module module_power_reset_sequencer_bench;
  // ----------------------------------------------------------------
  // Shortened counts and signals
  // ----------------------------------------------------------------
  localparam int ON_C = 50, OFF_C = 100, ST_C = 5, RST_C = 20, USB_C = 400, UART_C = 300;
  logic core_clk, arst_n, req_on, req_off, req_reset;
  logic busy, mod_up, uart_ready, usb_ready, powered, rebooting;
  int   miscompares, n_tests, t0, tk;
  int   cyc = 0;

  pwr_seq_if pins_if ();
  host_pwr_seq #(.ON_CYC(ON_C), .OFF_CYC(OFF_C), .STAT_CYC(ST_C), .RST_CYC(RST_C), .USB_CYC(USB_C),
    .UART_CYC(UART_C)) host_pwr_seq_inst (.core_clk(core_clk), .arst_n(arst_n), .pins(pins_if.host_end),
    .req_on(req_on), .req_off(req_off), .req_reset(req_reset), .busy(busy), .mod_up(mod_up),
    .uart_ready(uart_ready), .usb_ready(usb_ready));
  modem_pwr_end #(.ON_DET_CYC(10), .OFF_DET_CYC(OFF_C), .STAT_CYC(ST_C), .RST_DET_CYC(10), .BOOT_CYCS(8))
    modem_pwr_end_inst (.core_clk(core_clk), .arst_n(arst_n), .pins(pins_if.module_end), .powered(powered),
    .rebooting(rebooting));
  pwr_seq_properties #(.ON_CYC(ON_C), .OFF_CYC(OFF_C), .RST_CYC(RST_C), .STAT_CYC(ST_C))
    pwr_seq_properties_inst (.core_clk(core_clk), .arst_n(arst_n), .power_key_n(pins_if.power_key_n),
    .reset_n(pins_if.reset_n), .aux_rail_out(pins_if.aux_rail_out), .status_o(pins_if.status_o),
    .status_oe_n(pins_if.status_oe_n), .status_pin(pins_if.status_pin));

  // Clock and a cycle count read at falling edges
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // Watched outputs by index, so one wait task serves all
  function automatic logic obs(input int k);
    case (k)
      1: return mod_up;
      2: return uart_ready;
      3: return usb_ready;
      4: return pins_if.power_key_n;
      5: return pins_if.reset_n;
      6: return pins_if.aux_rail_out;
      default: return pins_if.status_pin;
    endcase
  endfunction

  // Bounded wait; a hang shows as a mismatch, not a stall
  task automatic wait_for(input string what, input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (obs(k) !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk_bit(what, v, obs(k));
  endtask

  // One-cycle request pulse: 0 on, 1 off, 2 reset
  task automatic pulse(input int k);
    req_on = (k == 0);
    req_off = (k == 1);
    req_reset = (k == 2);
    t0 = cyc;
    @(negedge core_clk);
    {req_on, req_off, req_reset} = 3'h0;
  endtask

  // Key low span, timed from the first low sample
  task automatic key_press(input int lo, input int hi);
    wait_for("key low", 4, 1'b0, 3);
    tk = cyc;
    wait_for("key high", 4, 1'b1, hi + 2);
    chk_rng("key low width", lo, hi, cyc - tk);
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well past the expected 850 or so cycles
  initial begin
    repeat (6000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, req_on, req_off, req_reset} = 4'h0;
    miscompares = 0;
    n_tests = 0;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    chk_bit("status_pin", 1'b1, pins_if.status_pin);
    chk_bit("aux_rail_out", 1'b0, pins_if.aux_rail_out);
    // Off while idle must be ignored
    pulse(1);
    repeat (3) @(negedge core_clk);
    chk_bit("busy", 1'b0, busy);
    chk_bit("power_key_n", 1'b1, pins_if.power_key_n);
    // Power on and readiness timing
    pulse(0);
    chk_bit("busy", 1'b1, busy);
    wait_for("status_pin", 7, 1'b0, 40);
    chk_rng("status delay", ST_C, 40, cyc - t0);
    chk_bit("aux_rail_out", 1'b1, pins_if.aux_rail_out);
    chk_bit("power_key_n", 1'b0, pins_if.power_key_n);
    wait_for("key high", 4, 1'b1, ON_C + 2);
    chk_rng("on key width", ON_C, ON_C + 1, cyc - t0 - 2);
    wait_for("mod_up", 1, 1'b1, 20);
    chk_bit("uart_ready", 1'b0, uart_ready);
    wait_for("uart_ready", 2, 1'b1, UART_C);
    chk_rng("uart delay", UART_C - 2, UART_C + 6, cyc - t0);
    wait_for("usb_ready", 3, 1'b1, USB_C);
    chk_rng("usb delay", USB_C - 2, USB_C + 6, cyc - t0);
    // Hard reset while running, key must stay idle
    pulse(2);
    wait_for("reset low", 5, 1'b0, 3);
    tk = cyc;
    chk_bit("power_key_n", 1'b1, pins_if.power_key_n);
    wait_for("reset high", 5, 1'b1, RST_C + 2);
    chk_rng("reset width", RST_C, RST_C + 1, cyc - tk);
    chk_bit("rebooting", 1'b1, rebooting);
    chk_bit("powered", 1'b0, powered);
    t0 = cyc;
    chk_bit("uart_ready", 1'b0, uart_ready);
    wait_for("mod_up", 1, 1'b1, 100);
    wait_for("uart_ready", 2, 1'b1, UART_C + 8);
    chk_rng("uart after reset", UART_C - 2, UART_C + 6, cyc - t0);
    // Long press shuts down
    pulse(1);
    key_press(OFF_C, OFF_C + 1);
    wait_for("aux_rail_out", 6, 1'b0, 20);
    chk_bit("status_pin", 1'b1, pins_if.status_pin);
    chk_bit("powered", 1'b0, powered);
    wait_for("mod_up", 1, 1'b0, 10);
    chk_bit("usb_ready", 1'b0, usb_ready);
    give_verdict();
  end
endmodule
`default_nettype wire
